// ### design/vpfc_pkg.sv
// Shared constants and types for the video port format configuration block
package vpfc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VPFC_IN_REF_A_ADDR  = 8'h92;
  localparam logic [7:0] VPFC_OUT_FMT_A_ADDR = 8'h93;
  localparam logic [7:0] VPFC_IN_REF_B_ADDR  = 8'hc2;
  localparam logic [7:0] VPFC_OUT_FMT_B_ADDR = 8'hc3;
  localparam logic [7:0] VPFC_IN_REF_RST     = 8'h00;
  localparam logic [7:0] VPFC_OUT_FMT_RST    = 8'h00;
  localparam logic [7:0] VPFC_UNMAPPED_RD    = 8'h00;

  // ----------------------------------------------------------------
  // Embedded timing codes
  // ----------------------------------------------------------------
  localparam logic [7:0] VPFC_CODE_ONES  = 8'hff;
  localparam logic [7:0] VPFC_CODE_ZEROS = 8'h00;
  localparam logic [1:0] VPFC_CODE_TAIL  = 2'h3;
  localparam int         VPFC_XY_V_POS   = 5;
  localparam int         VPFC_XY_H_POS   = 4;
  localparam logic [7:0] VPFC_HIGH_IDLE  = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    VPFC_FMT_422 = 3'h0,
    VPFC_FMT_411 = 3'h1,
    VPFC_FMT_420 = 3'h2,
    VPFC_FMT_410 = 3'h3,
    VPFC_FMT_Y   = 3'h4
  } vpfc_fmt_t;

  typedef enum logic [3:0] {
    VPFC_SCAN_SEEK  = 4'h1,
    VPFC_SCAN_ONES  = 4'h2,
    VPFC_SCAN_ZERO1 = 4'h4,
    VPFC_SCAN_ZERO2 = 4'h8
  } vpfc_scan_t;

  typedef struct packed {
    logic vfield_def;
    logic hfield_def;
    logic vref_kind_select;
    logic vref_edge_select;
    logic embedded_reference_select;
    logic href_edge_select;
    logic qualifier_polarity;
    logic qualifier_bypass_select;
  } vpfc_in_cfg_t;

  typedef struct packed {
    logic       output_code_insert_enable;
    logic       output_word_width_select;
    logic       lead_luma_skip_enable;
    logic [1:0] leading_line_count;
    vpfc_fmt_t  output_chroma_format;
  } vpfc_out_cfg_t;

  typedef struct packed {
    vpfc_in_cfg_t  in_ref;
    vpfc_out_cfg_t out_fmt;
  } vpfc_cfg_t;

  localparam vpfc_cfg_t VPFC_CFG_RST = vpfc_cfg_t'({VPFC_IN_REF_RST, VPFC_OUT_FMT_RST});

  typedef struct packed {
    logic [7:0] data;
    logic       qualifier;
    logic       href;
    logic       vref;
  } vpfc_xin_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       qualifier;
  } vpfc_iout_t;

endpackage

// ### design/vpfc_cfg_xfer.sv
// Handshake that carries the active configuration word into the port clock domain
`timescale 1ns/1ps
module vpfc_cfg_xfer
(
  input  logic              clk_in,
  input  logic              rst_in,
  input  vpfc_pkg::vpfc_cfg_t word_in,
  input  logic              link_clk_in,
  input  logic              link_rst_in,
  output vpfc_pkg::vpfc_cfg_t word_out
);
  import vpfc_pkg::*;

  typedef struct packed {
    vpfc_cfg_t word;
    logic      req;
    logic      ack_s1;
    logic      ack_s2;
  } vpfc_xsrc_t;

  typedef struct packed {
    vpfc_cfg_t word;
    logic      req_s1;
    logic      req_s2;
    logic      ack;
  } vpfc_xdst_t;

  vpfc_xsrc_t src;
  vpfc_xsrc_t next_src;
  vpfc_xdst_t dst;
  vpfc_xdst_t next_dst;

  // ----------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------
  always_comb
  begin
    next_src        = src;
    next_src.ack_s1 = dst.ack;
    next_src.ack_s2 = src.ack_s1;
    // A new word is offered only after the port side has taken the last one
    if ((src.req == src.ack_s2) && (word_in != src.word))
    begin
      next_src.word = word_in;
      next_src.req  = ~src.req;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      src <= '{VPFC_CFG_RST, 1'b0, 1'b0, 1'b0};
    else
      src <= next_src;
  end

  // ----------------------------------------------------------------
  // Port side
  // ----------------------------------------------------------------
  always_comb
  begin
    next_dst        = dst;
    next_dst.req_s1 = src.req;
    next_dst.req_s2 = dst.req_s1;
    // The offered word stays still until our toggle returns, so sampling it is safe
    if (dst.req_s2 != dst.ack)
    begin
      next_dst.word = src.word;
      next_dst.ack  = dst.req_s2;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_in)
      dst <= '{VPFC_CFG_RST, 1'b0, 1'b0, 1'b0};
    else
      dst <= next_dst;
  end

  assign word_out = dst.word;

endmodule

// ### design/vpfc_top.sv
// Video port format configuration: task registers, input reference decode, output formatter
`timescale 1ns/1ps
module vpfc_top
(
  input  logic       clk_in,
  input  logic       rst_in,
  input  logic [7:0] sub_addr_in,
  input  logic [7:0] wr_data_in,
  input  logic       wr_en_in,
  input  logic       task_set_select_in,
  output logic [7:0] rd_data_out,
  input  logic       expansion_port_clock_in,
  input  logic [7:0] expansion_data_in,
  input  logic       expansion_data_qualifier_in,
  input  logic       horizontal_reference_in,
  input  logic       vertical_reference_in,
  input  logic       decoder_vertical_pulse_in,
  output logic [7:0] output_data_bus_out,
  output logic [7:0] host_port_data_bus_out,
  output logic       output_qualifier_out
);
  import vpfc_pkg::*;

  typedef struct packed {
    vpfc_in_cfg_t  in_a;
    vpfc_out_cfg_t out_a;
    vpfc_in_cfg_t  in_b;
    vpfc_out_cfg_t out_b;
    logic [7:0]    rd_data;
  } vpfc_core_t;

  typedef struct packed {
    vpfc_xin_t  pin;
    logic       href_d;
    logic       vref_d;
    logic       vpulse_s1;
    logic       vpulse_s2;
    logic       vpulse_d;
    vpfc_scan_t scan;
    logic       vbit;
    logic       field;
    logic       started;
    logic [1:0] lead_left;
    logic [1:0] chroma_ph;
    logic [2:0] bph;
    logic [1:0] ins_cnt;
    logic [7:0] hold;
    logic       hold_vld;
    vpfc_iout_t out;
  } vpfc_link_t;

  vpfc_core_t core;
  vpfc_core_t next_core;
  vpfc_cfg_t  active_cfg;
  vpfc_cfg_t  cfg;
  vpfc_link_t lnk;
  vpfc_link_t next_lnk;
  logic [1:0] link_rst_sync;
  logic       link_rst;
  logic       in_vld;
  logic       href_ev;
  logic       vpin_ev;
  logic       vpulse_ev;
  logic       code_hit;
  logic       line_ev;
  logic       vert_ev;
  logic       ins_act;
  logic [7:0] code_byte;
  logic       lead_line;
  logic       chroma_line;
  logic       keep;
  logic       sb_vld;
  logic [7:0] sb;
  logic       hv;

  // ----------------------------------------------------------------
  // Task register sets
  // ----------------------------------------------------------------
  always_comb
  begin
    next_core = core;
    if (wr_en_in)
    begin
      case (sub_addr_in)
        VPFC_IN_REF_A_ADDR:  next_core.in_a  = vpfc_in_cfg_t'(wr_data_in);
        VPFC_OUT_FMT_A_ADDR: next_core.out_a = vpfc_out_cfg_t'(wr_data_in);
        VPFC_IN_REF_B_ADDR:  next_core.in_b  = vpfc_in_cfg_t'(wr_data_in);
        VPFC_OUT_FMT_B_ADDR: next_core.out_b = vpfc_out_cfg_t'(wr_data_in);
        default:             next_core.rd_data = core.rd_data;
      endcase
    end
    case (sub_addr_in)
      VPFC_IN_REF_A_ADDR:  next_core.rd_data = core.in_a;
      VPFC_OUT_FMT_A_ADDR: next_core.rd_data = core.out_a;
      VPFC_IN_REF_B_ADDR:  next_core.rd_data = core.in_b;
      VPFC_OUT_FMT_B_ADDR: next_core.rd_data = core.out_b;
      default:             next_core.rd_data = VPFC_UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      core <= '{VPFC_IN_REF_RST, VPFC_OUT_FMT_RST, VPFC_IN_REF_RST, VPFC_OUT_FMT_RST,
                VPFC_UNMAPPED_RD};
    else
      core <= next_core;
  end

  // Only one set steers the ports at a time
  always_comb
  begin
    active_cfg.in_ref  = task_set_select_in ? core.in_b : core.in_a;
    active_cfg.out_fmt = task_set_select_in ? core.out_b : core.out_a;
  end

  vpfc_cfg_xfer u_xfer
  (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .word_in     (active_cfg),
    .link_clk_in (expansion_port_clock_in),
    .link_rst_in (link_rst),
    .word_out    (cfg)
  );

  // ----------------------------------------------------------------
  // Port clock reset
  // ----------------------------------------------------------------
  // The port clock may stop between frames, so reset reaches this side only while it runs
  always_ff @(posedge expansion_port_clock_in)
  begin
    link_rst_sync <= {link_rst_sync[0], rst_in};
  end
  assign link_rst = link_rst_sync[1];

  // ----------------------------------------------------------------
  // Input qualification and reference decode
  // ----------------------------------------------------------------
  always_comb
  begin
    in_vld    = cfg.in_ref.qualifier_bypass_select
              | (lnk.pin.qualifier ^ cfg.in_ref.qualifier_polarity);
    href_ev   = cfg.in_ref.href_edge_select ? (lnk.href_d & ~lnk.pin.href)
                                            : (~lnk.href_d & lnk.pin.href);
    if (cfg.in_ref.vref_kind_select)
      vpin_ev = lnk.vref_d ^ lnk.pin.vref;
    else
      vpin_ev = cfg.in_ref.vref_edge_select ? (lnk.vref_d & ~lnk.pin.vref)
                                            : (~lnk.vref_d & lnk.pin.vref);
    vpulse_ev = cfg.in_ref.vref_edge_select ? (lnk.vpulse_d & ~lnk.vpulse_s2)
                                            : (~lnk.vpulse_d & lnk.vpulse_s2);
    code_hit  = in_vld & (lnk.scan == VPFC_SCAN_ZERO2);
    if (cfg.in_ref.embedded_reference_select)
    begin
      line_ev = code_hit & ~lnk.pin.data[VPFC_XY_H_POS];
      vert_ev = code_hit & lnk.pin.data[VPFC_XY_V_POS] & ~lnk.vbit;
    end
    else
    begin
      line_ev = href_ev;
      vert_ev = vpin_ev | vpulse_ev;
    end
    // Inserted code bytes take the slot of incoming bytes, which are lost meanwhile
    ins_act   = (line_ev & cfg.out_fmt.output_code_insert_enable)
              | (lnk.ins_cnt != 2'h0);
    if (line_ev)
      code_byte = VPFC_CODE_ONES;
    else if (lnk.ins_cnt == 2'h1)
      code_byte = {1'b1, lnk.field, 3'h0, {3{lnk.field}}};
    else
      code_byte = VPFC_CODE_ZEROS;
    lead_line = lnk.lead_left != 2'h0;
    case (cfg.out_fmt.output_chroma_format)
      VPFC_FMT_422: chroma_line = 1'b1;
      VPFC_FMT_411: chroma_line = 1'b1;
      VPFC_FMT_420: chroma_line = ~lnk.chroma_ph[0];
      VPFC_FMT_410: chroma_line = lnk.chroma_ph == 2'h0;
      default:      chroma_line = 1'b0;
    endcase
    chroma_line = chroma_line & ~lead_line;
    keep      = in_vld & lnk.started & ~line_ev & ~ins_act
              & ~(lead_line & cfg.out_fmt.lead_luma_skip_enable)
              & (lnk.bph[0] | (chroma_line
                 & ~((cfg.out_fmt.output_chroma_format == VPFC_FMT_411)
                     & lnk.bph[2] & ~lnk.bph[0])));
    sb_vld    = ins_act | keep;
    sb        = ins_act ? code_byte : lnk.pin.data;
    hv        = lnk.hold_vld & ~line_ev;
  end

  // ----------------------------------------------------------------
  // Port clock state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_lnk           = lnk;
    next_lnk.pin       = '{expansion_data_in, expansion_data_qualifier_in,
                           horizontal_reference_in, vertical_reference_in};
    next_lnk.href_d    = lnk.pin.href;
    next_lnk.vref_d    = lnk.pin.vref;
    next_lnk.vpulse_s1 = decoder_vertical_pulse_in;
    next_lnk.vpulse_s2 = lnk.vpulse_s1;
    next_lnk.vpulse_d  = lnk.vpulse_s2;
    if (in_vld)
    begin
      case (lnk.scan)
        VPFC_SCAN_SEEK:
          next_lnk.scan = (lnk.pin.data == VPFC_CODE_ONES) ? VPFC_SCAN_ONES : VPFC_SCAN_SEEK;
        VPFC_SCAN_ONES:
          if (lnk.pin.data == VPFC_CODE_ZEROS)
            next_lnk.scan = VPFC_SCAN_ZERO1;
          else
            next_lnk.scan = (lnk.pin.data == VPFC_CODE_ONES) ? VPFC_SCAN_ONES : VPFC_SCAN_SEEK;
        VPFC_SCAN_ZERO1:
          next_lnk.scan = (lnk.pin.data == VPFC_CODE_ZEROS) ? VPFC_SCAN_ZERO2 : VPFC_SCAN_SEEK;
        default:
          next_lnk.scan = VPFC_SCAN_SEEK;
      endcase
    end
    if (code_hit)
      next_lnk.vbit = lnk.pin.data[VPFC_XY_V_POS];
    if (vert_ev)
    begin
      next_lnk.field     = ~lnk.field;
      next_lnk.started   = 1'b0;
      next_lnk.lead_left = cfg.out_fmt.leading_line_count;
      next_lnk.chroma_ph = 2'h0;
    end
    else if (line_ev)
    begin
      if (!lnk.started)
        next_lnk.started = 1'b1;
      else if (lead_line)
        next_lnk.lead_left = lnk.lead_left - 2'h1;
      else
        next_lnk.chroma_ph = lnk.chroma_ph + 2'h1;
    end
    if (line_ev)
      next_lnk.bph = 3'h0;
    else if (in_vld && !ins_act)
      next_lnk.bph = lnk.bph + 3'h1;
    if (line_ev && cfg.out_fmt.output_code_insert_enable)
      next_lnk.ins_cnt = VPFC_CODE_TAIL;
    else if (lnk.ins_cnt != 2'h0)
      next_lnk.ins_cnt = lnk.ins_cnt - 2'h1;
    next_lnk.out.qualifier = 1'b0;
    if (!cfg.out_fmt.output_word_width_select)
    begin
      next_lnk.hold_vld = 1'b0;
      if (sb_vld)
      begin
        next_lnk.out = '{sb, VPFC_HIGH_IDLE, 1'b1};
      end
    end
    else if (sb_vld && hv)
    begin
      next_lnk.out      = '{lnk.hold, sb, 1'b1};
      next_lnk.hold_vld = 1'b0;
    end
    else if (sb_vld)
    begin
      next_lnk.hold     = sb;
      next_lnk.hold_vld = 1'b1;
    end
    else if (line_ev)
      next_lnk.hold_vld = 1'b0;
  end

  always_ff @(posedge expansion_port_clock_in)
  begin
    if (link_rst)
    begin
      lnk         <= '0;
      lnk.scan    <= VPFC_SCAN_SEEK;
      lnk.started <= 1'b1;
    end
    else
      lnk <= next_lnk;
  end

  assign rd_data_out            = core.rd_data;
  assign output_data_bus_out    = lnk.out.low;
  assign host_port_data_bus_out = lnk.out.high;
  assign output_qualifier_out   = lnk.out.qualifier;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_set_rd;
    @(posedge clk_in) disable iff (rst_in)
    (wr_en_in && sub_addr_in == VPFC_OUT_FMT_B_ADDR) ##1 (sub_addr_in == VPFC_OUT_FMT_B_ADDR)
    |=> (rd_data_out == $past(wr_data_in, 2));
  endproperty
  a_set_rd: assert property (p_set_rd) else $error("Set B readback wrong");

  property p_bypass;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.in_ref.qualifier_bypass_select && !cfg.out_fmt.output_word_width_select && keep)
    |=> (output_qualifier_out && output_data_bus_out == $past(lnk.pin.data));
  endproperty
  a_bypass: assert property (p_bypass) else $error("Kept byte not output");

  property p_polarity;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (!cfg.in_ref.qualifier_bypass_select
     && lnk.pin.qualifier == cfg.in_ref.qualifier_polarity) |-> !keep;
  endproperty
  a_polarity: assert property (p_polarity) else $error("Unqualified byte kept");

  property p_href;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (!cfg.in_ref.embedded_reference_select && cfg.in_ref.href_edge_select
     && $fell(lnk.pin.href)) |-> line_ev;
  endproperty
  a_href: assert property (p_href) else $error("Falling line edge missed");

  property p_emb;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.in_ref.embedded_reference_select && lnk.scan != VPFC_SCAN_ZERO2) |-> !line_ev;
  endproperty
  a_emb: assert property (p_emb) else $error("Line start without code");

  property p_skip;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.out_fmt.lead_luma_skip_enable && lnk.lead_left != 2'h0) |-> !keep;
  endproperty
  a_skip: assert property (p_skip) else $error("Leading line not skipped");

  property p_wide;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.out_fmt.output_word_width_select && output_qualifier_out) |=> !output_qualifier_out;
  endproperty
  a_wide: assert property (p_wide) else $error("Word output too often");

  sequence s_code_start;
    cfg.out_fmt.output_code_insert_enable && !cfg.out_fmt.output_word_width_select && line_ev;
  endsequence
  sequence s_code_body;
    (output_qualifier_out && !line_ev) [*4];
  endsequence
  property p_code;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    s_code_start |=> s_code_body;
  endproperty
  a_code: assert property (p_code) else $error("Code not framed for four bytes");

  property p_411;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.out_fmt.output_chroma_format == VPFC_FMT_411 && lnk.bph == 3'h4) |-> !keep;
  endproperty
  a_411: assert property (p_411) else $error("Extra chroma kept");

  property p_420;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.out_fmt.output_chroma_format == VPFC_FMT_420 && lnk.chroma_ph[0] && !lnk.bph[0])
    |-> !keep;
  endproperty
  a_420: assert property (p_420) else $error("Chroma on odd line");

  property p_410;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (cfg.out_fmt.output_chroma_format == VPFC_FMT_410 && lnk.chroma_ph != 2'h0
     && !lnk.bph[0]) |-> !keep;
  endproperty
  a_410: assert property (p_410) else $error("Chroma off fourth line");

  property p_lead;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (lnk.lead_left != 2'h0 && !lnk.bph[0]) |-> !keep;
  endproperty
  a_lead: assert property (p_lead) else $error("Chroma on leading line");

  property p_vref;
    @(posedge expansion_port_clock_in) disable iff (link_rst)
    (!cfg.in_ref.embedded_reference_select && !cfg.in_ref.vref_kind_select
     && !cfg.in_ref.vref_edge_select && $rose(lnk.pin.vref)) |=> !lnk.started;
  endproperty
  a_vref: assert property (p_vref) else $error("Rising field edge missed");

endmodule

// ### verif/vpfc_src_model.sv
// Digital video source model driving the expansion port pins
`timescale 1ns/1ps
module vpfc_src_model
(
  input  wire logic       pclk_in,
  input  wire logic       idle_qual_in,
  output logic [7:0] data_out,
  output logic       qual_out,
  output logic       href_out,
  output logic       busy_out
);
  logic [9:0] q[$];
  logic [9:0] w;

  initial
  begin
    {href_out, qual_out, data_out, busy_out} = 11'h000;
  end

  task automatic send(input logic [7:0] d, input logic qv, input logic h);
    q.push_back({h, qv, d});
  endtask

  // Idle data keeps changing so a stale byte never passes for a real one
  always @(posedge pclk_in)
  begin
    #1;
    if (q.size() != 0)
    begin
      w = q.pop_front();
      {href_out, qual_out, data_out} <= w;
      busy_out <= 1'b1;
    end
    else
    begin
      data_out <= ~data_out;
      qual_out <= idle_qual_in;
      href_out <= 1'b0;
      busy_out <= 1'b0;
    end
  end
endmodule

// ### verif/tb.sv
// Self-checking bench for the video port format configuration block
`timescale 1ns/1ps
module tb;
  import vpfc_pkg::*;
  logic        clk_in = 0, pclk = 0, rst_in = 1, wr_en = 0, set_sel = 0, idle_qual = 0;
  logic [7:0]  sub_addr = 0, wr_data = 0, rd_data, xdata, obus, hbus, cur_in, cur_out, pend;
  logic        xqual, href, busy, oqual, has_pend, prev_h;
  logic [1:0]  mon_d = 0;
  logic [15:0] expq[$];
  logic [7:0]  adr[4] = '{VPFC_IN_REF_A_ADDR, VPFC_OUT_FMT_A_ADDR,
                          VPFC_IN_REF_B_ADDR, VPFC_OUT_FMT_B_ADDR};
  int          n_errors = 0, compares = 0, seed = 1, drop = 0, pos = 0;

  always #50 clk_in = ~clk_in;
  initial
  begin
    #1.3;
    forever #3 pclk = ~pclk;
  end

  vpfc_top vpfc_top_i (.clk_in(clk_in), .rst_in(rst_in), .sub_addr_in(sub_addr),
    .wr_data_in(wr_data), .wr_en_in(wr_en), .task_set_select_in(set_sel),
    .rd_data_out(rd_data), .expansion_port_clock_in(pclk), .expansion_data_in(xdata),
    .expansion_data_qualifier_in(xqual), .horizontal_reference_in(href),
    .vertical_reference_in(1'b0), .decoder_vertical_pulse_in(1'b0),
    .output_data_bus_out(obus), .host_port_data_bus_out(hbus), .output_qualifier_out(oqual));
  vpfc_src_model vpfc_src_model_i (.pclk_in(pclk), .idle_qual_in(idle_qual),
    .data_out(xdata), .qual_out(xqual), .href_out(href), .busy_out(busy));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 {sub_addr, wr_data, wr_en} = {a, d, 1'b1};
    @(posedge clk_in);
    #1 wr_en = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    #1 sub_addr = a;
    repeat (2) @(posedge clk_in);
    #1 check("rd_data", {8'h00, rd_data}, {8'h00, exp});
  endtask

  // Reference model of the port path, fed from the pins each port clock
  always @(posedge pclk)
  begin
    if (busy)
    begin
      // Pins give line starts only while embedded references are off
      if (!cur_in[3] && href != prev_h && href == ~cur_in[2])
      begin
        has_pend = 0;
        drop = 1;
        pos = 0;
        if (cur_out[7])
        begin
          expq.push_back({VPFC_HIGH_IDLE, VPFC_CODE_ONES});
          expq.push_back({VPFC_HIGH_IDLE, VPFC_CODE_ZEROS});
          expq.push_back({VPFC_HIGH_IDLE, VPFC_CODE_ZEROS});
          expq.push_back({VPFC_HIGH_IDLE, 8'h80});
          drop = 4;
        end
      end
      if (drop > 0)
        drop--;
      else if (cur_in[0] || xqual == ~cur_in[1])
      begin
        pos++;
        // Even positions carry luma; chroma kept per format
        if (pos % 2 == 0 || cur_out[2:0] == 3'h0
            || (cur_out[2:0] == 3'h1 && pos % 8 != 5 && pos % 8 != 7))
        begin
          if (!cur_out[6])
            expq.push_back({VPFC_HIGH_IDLE, xdata});
          else if (has_pend)
          begin
            expq.push_back({xdata, pend});
            has_pend = 0;
          end
          else
            {pend, has_pend} = {xdata, 1'b1};
        end
      end
    end
    prev_h = href;
  end

  always @(posedge pclk)
  begin
    mon_d <= {mon_d[0], busy};
    if (mon_d[1] && oqual === 1'b1)
      check("out_word", {hbus, obus}, expq.size() ? expq.pop_front() : 16'hxxxx);
  end

  task automatic stream(input logic s, input logic [7:0] ir, input logic [7:0] orr,
                        input int hs);
    int i;
    wr(s ? VPFC_IN_REF_B_ADDR : VPFC_IN_REF_A_ADDR, ir);
    wr(s ? VPFC_OUT_FMT_B_ADDR : VPFC_OUT_FMT_A_ADDR, orr);
    @(posedge clk_in);
    #1 {set_sel, idle_qual, cur_in, cur_out, has_pend} = {s, ir[1], ir, orr, 1'b0};
    drop = 0;
    // Config crosses by handshake, so give the port side time to follow
    repeat (30) @(posedge clk_in);
    for (i = 0; i < 24; i++)
      vpfc_src_model_i.send(8'($random(seed)), 1'($random(seed)), i >= hs && i < 15);
    repeat (80) @(posedge pclk);
    check("left_over", 16'(expq.size()), 16'h0000);
    $display("stream done cfg %h %h", ir, orr);
  endtask

  initial
  begin
    repeat (5) @(posedge clk_in);
    #1 rst_in = 0;
    foreach (adr[k]) rd(adr[k], 8'h00);
    foreach (adr[k])
    begin
      pend = 8'($random(seed)) & 8'hfb;
      wr(adr[k], pend);
      rd(adr[k], pend);
    end
    wr(8'h94, 8'h5a);
    rd(8'h94, VPFC_UNMAPPED_RD);
    $display("registers done");
    stream(0, 8'h01, 8'h00, 24);
    stream(1, 8'h00, 8'h00, 24);
    stream(1, 8'h02, 8'h00, 24);
    stream(0, 8'h02, 8'h40, 24);
    stream(0, 8'h01, 8'h80, 6);
    stream(1, 8'h05, 8'h80, 6);
    stream(1, 8'h09, 8'h00, 6);
    stream(0, 8'h00, 8'h04, 0);
    stream(1, 8'h02, 8'h01, 0);
    print_verdict;
  end

  initial
  begin
    #200000;
    n_errors++;
    print_verdict;
  end
endmodule
